// >>> hw/msc_stat_counters.sv
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ns
`include "msc_consts.svh"
module msc_stat_counters
  import msc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_done,
  input  wire logic        tx_underrun,
  input  wire logic        tx_retry_exceeded,
  input  wire logic [4:0]  tx_coll_count,
  input  wire logic        tx_late_coll,
  input  wire logic        tx_deferred,
  input  wire logic        rx_done,
  input  wire logic [13:0] rx_len,
  input  wire logic        rx_fractional,
  input  wire logic        rx_crc_bad,
  input  wire logic        rx_symbol_err,
  input  wire logic        rx_addr_match,
  input  wire logic        rx_copied
);

  // ========================================================================
  // helpers
  function automatic logic [23:0] cnt_mask(input logic [2:0] idx);
    unique case (idx)
      CNT_TX_OK, CNT_RX_OK:             cnt_mask = `MSC_MASK_24;
      CNT_SINGLE, CNT_MULTI, CNT_DEFERRED: cnt_mask = `MSC_MASK_16;
      CNT_CRC, CNT_ALIGN, CNT_LATE_COLL: cnt_mask = `MSC_MASK_8;
    endcase
  endfunction

  // sticks at the counter's own all-ones value instead of wrapping
  function automatic logic [23:0] sat_inc(input logic [23:0] val, input logic [2:0] idx);
    if (val == cnt_mask(idx))
    begin
      sat_inc = val;
    end
    else
    begin
      sat_inc = val + 24'h00_0001;
    end
  endfunction

  // ========================================================================
  // state
  msc_apb_state_t state_q;
  msc_apb_state_t state_d;
  logic [31:0]    ctrl_q;
  logic [31:0]    ctrl_d;
  logic [31:0]    cfg_q;
  logic [31:0]    cfg_d;
  logic [23:0]    cnt_q [8];
  logic [23:0]    cnt_d [8];
  logic [31:0]    prdata_q;
  logic [31:0]    prdata_d;
  logic           pready_q;
  logic           pready_d;
  logic           pslverr_q;
  logic           pslverr_d;

  // ========================================================================
  // bus decode
  logic        acc;
  logic        cnt_sel;
  logic        ctrl_sel;
  logic        cfg_sel;
  logic        mapped;
  logic [5:0]  word_idx;
  logic [2:0]  cnt_idx;
  logic        rd_clr;
  logic        cnt_wr;
  logic [31:0] rd_val;

  // one wait state: the action happens on the first access edge, pready follows
  assign acc      = psel & penable & (state_q == ST_IDLE);
  assign ctrl_sel = (paddr == `MSC_OFS_NET_CTRL);
  assign cfg_sel  = (paddr == `MSC_OFS_NET_CFG);
  assign cnt_sel  = (paddr >= `MSC_OFS_CNT_FIRST) && (paddr <= `MSC_OFS_CNT_LAST)
                    && (paddr[1:0] == 2'b00);
  assign mapped   = ctrl_sel | cfg_sel | cnt_sel;
  // paddr[7:2] is already a word number, so the base is taken in words too
  assign word_idx = paddr[7:2] - 6'(`MSC_OFS_CNT_FIRST >> 2);
  assign cnt_idx  = word_idx[2:0];
  assign rd_clr   = acc & ~pwrite & cnt_sel;
  assign cnt_wr   = acc & pwrite & cnt_sel & ctrl_q[`MSC_CTRL_STAT_WE_BIT];

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (cnt_sel)
    begin
      rd_val = {8'h00, cnt_q[cnt_idx] & cnt_mask(cnt_idx)};
    end
    else if (ctrl_sel)
    begin
      rd_val = ctrl_q;
    end
    else if (cfg_sel)
    begin
      rd_val = cfg_q;
    end
  end

  // the access phase is still up while the answer stands; it must not act twice
  always_comb
  begin
    unique case (state_q)
      ST_IDLE: state_d = acc ? ST_ACK : ST_IDLE;
      ST_ACK:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // read data stands only in the answer cycle, so an idle bus shows zero
  always_comb
  begin
    pready_d  = acc;
    pslverr_d = acc & ~mapped;
    prdata_d  = prdata_q;
    if (acc & ~pwrite)
    begin
      prdata_d = rd_val;
    end
    else if (pready_q)
    begin
      prdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ========================================================================
  // control and configuration
  always_comb
  begin
    ctrl_d = ctrl_q;
    cfg_d  = cfg_q;
    if (acc & pwrite & ctrl_sel)
    begin
      // bits with no function are dropped so they read back as zero
      ctrl_d = pwdata & `MSC_CTRL_MASK;
    end
    if (acc & pwrite & cfg_sel)
    begin
      cfg_d = pwdata & `MSC_CFG_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `MSC_CTRL_RESET;
      cfg_q  <= `MSC_CFG_RESET;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      cfg_q  <= cfg_d;
    end
  end

  // ========================================================================
  // frame qualification
  logic [4:0]  coll_total;
  logic        tx_clean;
  logic        tx_ok;
  logic        tx_single;
  logic        tx_multi;
  logic        tx_defer;
  logic        tx_late;
  logic [13:0] len_max;
  logic        len_ok;
  logic        rx_bad;
  logic        rx_en;
  logic        rx_good;
  logic        rx_whole_err;
  logic        rx_frac_err;
  logic [7:0]  inc;

  // late collision is folded into the collision total so it is counted twice
  assign coll_total = tx_coll_count + {4'h0, tx_late_coll};
  // an underrun frame touches no counter at all
  assign tx_clean  = tx_done & ~tx_underrun;
  assign tx_ok     = tx_clean & ~tx_retry_exceeded;
  assign tx_single = tx_ok & (coll_total == `MSC_COLL_ONE);
  assign tx_multi  = tx_ok & (coll_total >= `MSC_COLL_TWO)
                     & (coll_total <= `MSC_COLL_MAX_OK);
  // any collision, a late one too, keeps a frame out of the deferral count, except 31 plus a late one, whose 5-bit total wraps to zero
  assign tx_defer  = tx_clean & tx_deferred & (coll_total == 5'h00);
  // collision after the 512-bit slot time is flagged by the transmitter
  assign tx_late   = tx_clean & tx_late_coll;
  assign len_max = cfg_q[`MSC_CFG_BIG_FRAME_BIT] ? `MSC_LEN_MAX_BIG : `MSC_LEN_MAX;
  assign len_ok  = (rx_len >= `MSC_LEN_MIN) && (rx_len <= len_max);
  // a symbol error lands where a bad CRC of the same byte alignment would
  assign rx_bad  = rx_crc_bad | rx_symbol_err;
  assign rx_en   = rx_done & ctrl_q[`MSC_CTRL_RX_EN_BIT];
  assign rx_good      = rx_en & len_ok & ~rx_bad & ~rx_fractional
                        & rx_addr_match & rx_copied;
  assign rx_whole_err = rx_en & len_ok & ~rx_fractional & rx_bad;
  assign rx_frac_err  = rx_en & len_ok & rx_fractional & rx_bad;

  always_comb
  begin
    inc = 8'h00;
    inc[CNT_TX_OK]     = tx_ok;
    inc[CNT_SINGLE]    = tx_single;
    inc[CNT_MULTI]     = tx_multi;
    inc[CNT_DEFERRED]  = tx_defer;
    inc[CNT_LATE_COLL] = tx_late;
    inc[CNT_RX_OK]     = rx_good;
    inc[CNT_CRC]       = rx_whole_err;
    inc[CNT_ALIGN]     = rx_frac_err;
  end

  // ========================================================================
  // counters
  // software write beats a same-cycle event; an event and a clear in the same cycle leave a count of one
  logic [7:0] cnt_hit;
  logic [7:0] cnt_load;
  logic [7:0] cnt_clr;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      cnt_hit[i]  = (cnt_idx == 3'(i));
      cnt_load[i] = cnt_wr & cnt_hit[i];
      cnt_clr[i]  = rd_clr & cnt_hit[i];
    end
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      cnt_d[i] = cnt_q[i];
      if (cnt_load[i])
      begin
        cnt_d[i] = pwdata[23:0] & cnt_mask(3'(i));
      end
      else if (inc[i])
      begin
        if (cnt_clr[i])
        begin
          // the read returns the old value, so this event must not be lost
          cnt_d[i] = 24'h00_0001;
        end
        else
        begin
          cnt_d[i] = sat_inc(cnt_q[i], 3'(i));
        end
      end
      else if (cnt_clr[i])
      begin
        cnt_d[i] = `MSC_CNT_RESET;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
      begin
        cnt_q[i] <= `MSC_CNT_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        cnt_q[i] <= cnt_d[i];
      end
    end
  end

endmodule

// >>> pkg/msc_consts.svh
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// ==========================================================================
// register offsets (byte addresses)
`define MSC_OFS_NET_CTRL  8'h00
`define MSC_OFS_NET_CFG   8'h04
`define MSC_OFS_CNT_FIRST 8'h10
`define MSC_OFS_CNT_LAST  8'h2c

// ==========================================================================
// control and configuration fields
`define MSC_CTRL_RX_EN_BIT    2
`define MSC_CTRL_STAT_WE_BIT  7
`define MSC_CFG_BIG_FRAME_BIT 8
`define MSC_CTRL_MASK         32'h0000_0084
`define MSC_CFG_MASK          32'h0000_0100
`define MSC_CTRL_RESET        32'h0000_0000
`define MSC_CFG_RESET         32'h0000_0000
`define MSC_CNT_RESET         24'h00_0000

// ==========================================================================
// counter widths as masks
`define MSC_MASK_24 24'hff_ffff
`define MSC_MASK_16 24'h00_ffff
`define MSC_MASK_8  24'h00_00ff

// ==========================================================================
// frame length limits in bytes, collision limits
`define MSC_LEN_MIN     14'h0040
`define MSC_LEN_MAX     14'h05ee
`define MSC_LEN_MAX_BIG 14'h0600
`define MSC_COLL_ONE    5'h01
`define MSC_COLL_TWO    5'h02
`define MSC_COLL_MAX_OK 5'h0f

`endif

// >>> pkg/msc_pkg.sv
package msc_pkg;

  // ========================================================================
  // counter slots, in address order from the first counter offset
  typedef enum logic [2:0] {
    CNT_TX_OK     = 3'b000,
    CNT_SINGLE    = 3'b001,
    CNT_MULTI     = 3'b010,
    CNT_RX_OK     = 3'b011,
    CNT_CRC       = 3'b100,
    CNT_ALIGN     = 3'b101,
    CNT_DEFERRED  = 3'b110,
    CNT_LATE_COLL = 3'b111
  } msc_cnt_t;

  // ========================================================================
  // bus answer phase
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_ACK  = 1'b1
  } msc_apb_state_t;

endpackage

// >>> verification/msc_stat_counters_sva.sv
`timescale 1ns/1ns
module msc_stat_counters_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  // =====
  // answer timing and read data shape
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  answer_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("answer late");
  answer_pulse_a: assert property (pready |=> !pready)
    else $error("answer held");
  answer_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("answer without access");
  err_shape_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error with data");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("data outside answer");
  tx_width_a: assert property (pready && paddr == 8'h10 |-> prdata[31:24] == 8'h00)
    else $error("wide tx count");
  half_width_a: assert property (pready && paddr inside {8'h14, 8'h18, 8'h28}
    |-> prdata[31:16] == 16'h0000)
    else $error("wide 16-bit count");
  byte_width_a: assert property (pready && paddr inside {8'h20, 8'h24, 8'h2c}
    |-> prdata[31:8] == 24'h00_0000)
    else $error("wide 8-bit count");
  unmapped_err_a: assert property (pready && paddr inside {8'h08, 8'h0c} |-> pslverr)
    else $error("hole accepted");
  cover property (pslverr);
  cover property (pready && !pwrite && prdata == 32'h00ff_ffff);
  cover property (pready && !pwrite && paddr == 8'h2c && prdata != 32'h0);
endmodule
bind msc_stat_counters msc_stat_counters_sva chk_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr);

// >>> verification/msc_mac_events.sv
`timescale 1ns/1ns
module msc_mac_events (
  input wire logic  pclk,
  output logic        tx_done,
  output logic        tx_underrun,
  output logic        tx_retry_exceeded,
  output logic [4:0]  tx_coll_count,
  output logic        tx_late_coll,
  output logic        tx_deferred,
  output logic        rx_done,
  output logic [13:0] rx_len,
  output logic        rx_fractional,
  output logic        rx_crc_bad,
  output logic        rx_symbol_err,
  output logic        rx_addr_match,
  output logic        rx_copied
);
  // =====
  // one frame outcome per call; qualifiers scrambled afterwards so stale values never count
  initial {tx_done, tx_underrun, tx_retry_exceeded, tx_coll_count, tx_late_coll, tx_deferred,
    rx_done, rx_len, rx_fractional, rx_crc_bad, rx_symbol_err, rx_addr_match, rx_copied} = '0;
  task automatic ev(input logic rx, input logic [4:0] c, input logic [4:0] fl,
    input logic [13:0] len);
    @(posedge pclk);
    tx_done <= !rx;
    rx_done <= rx;
    tx_coll_count <= c;
    {tx_underrun, tx_retry_exceeded, tx_late_coll, tx_deferred} <= fl[4:1];
    rx_len <= len;
    {rx_fractional, rx_crc_bad, rx_symbol_err, rx_addr_match, rx_copied} <= fl;
    @(posedge pclk);
    tx_done <= 1'b0;
    rx_done <= 1'b0;
    tx_coll_count <= ~c;
    {tx_underrun, tx_retry_exceeded, tx_late_coll, tx_deferred} <= ~fl[4:1];
    rx_len <= ~len;
    {rx_fractional, rx_crc_bad, rx_symbol_err, rx_addr_match, rx_copied} <= ~fl;
  endtask
endmodule

// >>> verification/tb_mac_statistics_counters.sv
`timescale 1ns/1ns
module tb_mac_statistics_counters;
  import msc_pkg::*;
  // =====
  // rows: tx fl = underrun,retry,late,defer,0; rx fl = frac,crc,symbol,match,copied
  typedef struct packed {logic rx; logic [4:0] c; logic [4:0] fl; logic [13:0] len;
    logic [7:0] e;} msc_row_t;
  msc_row_t rows [19] = '{'{0,0,0,0,8'h01}, '{0,1,0,0,8'h03}, '{0,2,0,0,8'h05},
    '{0,15,0,0,8'h05}, '{0,15,8,0,8'h00}, '{0,1,4,0,8'h85}, '{0,0,2,0,8'h41},
    '{0,1,2,0,8'h03}, '{0,0,18,0,8'h00}, '{1,0,3,64,8'h08}, '{1,0,3,1518,8'h08},
    '{1,0,3,1519,8'h00}, '{1,0,3,63,8'h00}, '{1,0,11,64,8'h10}, '{1,0,7,1518,8'h10},
    '{1,0,27,64,8'h20}, '{1,0,23,100,8'h20}, '{1,0,11,1519,8'h00}, '{1,0,2,64,8'h00}};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, err_q, tx_done, tx_underrun, tx_retry_exceeded;
  logic        tx_late_coll, tx_deferred, rx_done, rx_fractional, rx_crc_bad;
  logic        rx_symbol_err, rx_addr_match, rx_copied;
  logic [4:0]  tx_coll_count;
  logic [13:0] rx_len;
  int          failures = 0;
  int          checks = 0;
  always #25 pclk = ~pclk;
  msc_stat_counters dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .tx_done, .tx_underrun, .tx_retry_exceeded, .tx_coll_count,
    .tx_late_coll, .tx_deferred, .rx_done, .rx_len, .rx_fractional, .rx_crc_bad,
    .rx_symbol_err, .rx_addr_match, .rx_copied);
  msc_mac_events ev_u (.pclk, .tx_done, .tx_underrun, .tx_retry_exceeded, .tx_coll_count,
    .tx_late_coll, .tx_deferred, .rx_done, .rx_len, .rx_fractional, .rx_crc_bad,
    .rx_symbol_err, .rx_addr_match, .rx_copied);
  // =====
  // bus cycles, one idle cycle between transfers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask
  task automatic final_report();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // =====
  // reset values, then table and the awkward cases
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++)
      rd(8'(4 * i), 32'h0);
    apb(1'b1, 8'h00, 32'h4);
    foreach (rows[r])
    begin
      ev_u.ev(rows[r].rx, rows[r].c, rows[r].fl, rows[r].len);
      for (int i = 0; i < 8; i++)
        rd(8'h10 + 8'(4 * i), {31'h0, rows[r].e[i]});
    end
    apb(1'b1, 8'h04, 32'h100);
    ev_u.ev(1'b1, 5'h00, 5'h03, 14'd1536);
    ev_u.ev(1'b1, 5'h00, 5'h03, 14'd1537);
    rd(8'h1c, 32'h1);
    apb(1'b1, 8'h00, 32'h0);
    ev_u.ev(1'b1, 5'h00, 5'h03, 14'd100);
    ev_u.ev(1'b1, 5'h00, 5'h0b, 14'd100);
    rd(8'h1c, 32'h0);
    rd(8'h20, 32'h0);
    apb(1'b1, 8'h10, 32'h5);
    rd(8'h10, 32'h0);
    apb(1'b1, 8'h00, 32'h80);
    apb(1'b1, 8'h10, 32'hffff_ffff);
    ev_u.ev(1'b0, 5'h00, 5'h00, 14'd0);
    rd(8'h10, 32'h00ff_ffff);
    rd(8'h10, 32'h0);
    apb(1'b1, 8'h2c, 32'hffff_fffe);
    ev_u.ev(1'b0, 5'h00, 5'h04, 14'd0);
    ev_u.ev(1'b0, 5'h00, 5'h04, 14'd0);
    rd(8'h2c, 32'h0000_00ff);
    rd(8'h08, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    final_report();
  end
endmodule
